// [bench/sew_master.sv]
module sew_master (
  // clock and resolved data wire
  input  wire logic core_clk,
  input  wire logic sda_w,
  // driven link lines
  output logic      scl,
  output logic      sda_rel
);
  timeunit 1ns;
  timeprecision 1ns;
  // link clock stands high between frames, data released
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // start: data falls while clock high
  task automatic bus_start();
    tick(4);
    sda_rel = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  // one 800 ns bit; data moves a cycle after clock falls
  task automatic bit_cyc(input logic v, output logic s);
    tick(1);
    sda_rel = v;
    tick(3);
    scl = 1'b1;
    tick(2);
    s = sda_w;
    tick(2);
    scl = 1'b0;
  endtask
  // msb first, then ninth clock released to the pull-up
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
    bit_cyc(1'b1, s);
    ack = ~s;
  endtask
  // stop: data rises while clock high; then wait out sync and commit latency
  task automatic bus_stop();
    tick(1);
    sda_rel = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_rel = 1'b1;
    tick(8);
  endtask
endmodule

// [bench/sew_props.sv]
module sew_props
  import sew_pkg::*;
#(
  parameter int unsigned LOW_LIMIT_CYC = 200
) (
  // clock and reset
  input wire logic                           core_clk,
  input wire logic                           srst,
  // link
  input wire logic                           scl_in,
  input wire logic                           sda_out,
  input wire logic                           sda_oe,
  // write stream
  input wire logic                           nvm_wr_valid,
  input wire logic                           nvm_wr_ready,
  input wire logic [sew_pkg::ADDR_W-1:0]     nvm_wr_addr,
  input wire logic [7:0]                     nvm_wr_data,
  input wire logic                           nvm_busy,
  // status
  input wire logic [sew_pkg::NUM_BLOCKS-1:0] block_protect,
  input wire logic                           array_half,
  input wire logic                           bus_timeout
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [19:0] low_q;
  logic        to_q;
  logic [3:0]  scl_dl_q;
  // link clock four flops late: two for the sync, two for the pulse's own flops
  always_ff @(posedge core_clk) begin
    if (srst) scl_dl_q <= 4'hF;
    else scl_dl_q <= {scl_dl_q[2:0], scl_in};
  end
  // clock low run, lined up with the registered timeout pulse so trailing pulses fit
  always_ff @(posedge core_clk) begin
    if (srst || scl_dl_q[3]) low_q <= 20'h0;
    else if (low_q != 20'hFFFFF) low_q <= low_q + 20'h1;
  end
  // a timeout pulse seen in the present low run
  always_ff @(posedge core_clk) begin
    if (srst || scl_dl_q[3]) to_q <= 1'b0;
    else if (bus_timeout) to_q <= 1'b1;
  end
  chk_rst_vals: assert property (
    $fell(srst) |-> !sda_oe && !nvm_wr_valid && block_protect == PROT_RESET
      && array_half == HALF_RESET) else $error("reset values wrong");
  chk_drive_low: assert property (
    sda_oe |-> !sda_out) else $error("data pin driven high");
  chk_ack_len: assert property (
    $rose(sda_oe) |-> sda_oe [*5]) else $error("acknowledge too short");
  chk_busy_noack: assert property (
    nvm_busy [*8] |-> !$rose(sda_oe)) else $error("ack while array busy");
  chk_word_stand: assert property (
    nvm_wr_valid && !nvm_wr_ready |=> nvm_wr_valid && $stable(nvm_wr_addr)
      && $stable(nvm_wr_data)) else $error("stalled word changed");
  chk_prot_step: assert property (
    $changed(block_protect) |-> block_protect == 4'h0
      || ($countones(block_protect ^ $past(block_protect)) == 1
      && (block_protect & $past(block_protect)) == $past(block_protect)))
    else $error("protect flags moved wrongly");
  chk_prot_addr: assert property (
    nvm_wr_valid |-> !block_protect[{nvm_wr_addr[8], nvm_wr_addr[7]}])
    else $error("write into protected block");
  chk_half_addr: assert property (
    nvm_wr_valid |-> nvm_wr_addr[8] == array_half) else $error("wrong array half");
  chk_timeout_early: assert property (
    bus_timeout |-> low_q >= LOW_LIMIT_CYC - 1) else $error("timeout too early");
  chk_timeout_due: assert property (
    low_q == LOW_LIMIT_CYC + 8 |-> to_q || bus_timeout) else $error("timeout missing");
  cov_word: cover property (nvm_wr_valid && nvm_wr_ready);
  cov_timeout: cover property ($rose(bus_timeout));
  cov_half: cover property ($rose(array_half));
endmodule

bind sew_write_protect sew_props #(.LOW_LIMIT_CYC(LOW_LIMIT_CYC)) u_props (
  .core_clk(core_clk), .srst(srst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .nvm_wr_valid(nvm_wr_valid), .nvm_wr_ready(nvm_wr_ready),
  .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data), .nvm_busy(nvm_busy),
  .block_protect(block_protect), .array_half(array_half), .bus_timeout(bus_timeout));

// [bench/tb.sv]
module tb
  import sew_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned LIM = 200;
  logic core_clk, srst, scl, sda_rel, sda_w, sda_oe, sda_out, unlock;
  logic wr_valid, wr_ready, busy, write_busy, bus_timeout, array_half;
  logic [2:0]  pins;
  logic [8:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [3:0]  block_protect;
  logic [8:0]  q_addr[$];
  logic [7:0]  q_data[$];
  logic [2:0]  codes[4] = '{CODE_BLK0, CODE_BLK1, CODE_BLK2, CODE_BLK3};
  int err_total = 0;
  int checks = 0;
  int to_cnt = 0;
  // open-drain wire with pull-up
  assign sda_w = sda_rel & (sda_oe ? sda_out : 1'b1);
  sew_write_protect #(.LOW_LIMIT_CYC(LIM)) dut (
    .core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .select_input_zero(pins[0]), .select_input_one(pins[1]),
    .select_input_two(pins[2]), .elevated_unlock_voltage(unlock),
    .nvm_wr_valid(wr_valid), .nvm_wr_ready(wr_ready), .nvm_wr_addr(wr_addr),
    .nvm_wr_data(wr_data), .nvm_busy(busy), .block_protect(block_protect),
    .array_half(array_half), .write_busy(write_busy), .bus_timeout(bus_timeout));
  sew_master m (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda_rel(sda_rel));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // array sink: collect words taken, count timeout pulses
  always @(posedge core_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      q_addr.push_back(wr_addr);
      q_data.push_back(wr_data);
    end
    if (bus_timeout === 1'b1) to_cnt++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [7:0] b[$], output logic [31:0] acks);
    logic a;
    acks = '0;
    m.bus_start();
    foreach (b[i]) begin
      m.send_byte(b[i], a);
      acks[i] = a;
    end
    m.bus_stop();
  endtask
  task automatic memw(input logic [7:0] a, input logic [7:0] d, output logic [31:0] acks);
    frame('{{TYPE_MEM, pins, 1'b0}, a, d}, acks);
  endtask
  // queries are select only; others carry two ignored bytes
  task automatic cmd(input logic [2:0] c, input logic rw, output logic [31:0] acks);
    if (rw) frame('{{TYPE_CMD, c, rw}}, acks);
    else frame('{{TYPE_CMD, c, rw}, 8'hA5, 8'h3C}, acks);
  endtask
  task automatic fresh();
    q_addr.delete();
    q_data.delete();
  endtask
  // bounded wait, then a margin so late extra words show
  task automatic wait_words(input int n);
    for (int k = 0; k < 300 && q_addr.size() < n; k++) @(posedge core_clk);
    repeat (20) @(negedge core_clk);
    chk(q_addr.size(), n);
  endtask
  task automatic word(input int k, input logic [8:0] a, input logic [7:0] d);
    chk(q_addr[k], a);
    chk(q_data[k], d);
  endtask
  task automatic s_byte();
    logic [31:0] acks;
    fresh();
    memw(8'h35, 8'h5A, acks);
    chk(acks, 32'h7);
    wait_words(1);
    word(0, 9'h035, 8'h5A);
  endtask
  // 18 bytes from 2Eh with the sink stalled: only the last 16 survive
  task automatic s_page();
    logic [7:0] b[$];
    logic [31:0] acks;
    fresh();
    b = '{{TYPE_MEM, pins, 1'b0}, 8'h2E};
    for (int i = 0; i < 18; i++) b.push_back(8'h10 + 8'(i));
    wr_ready = 1'b0;
    frame(b, acks);
    chk(acks, 32'hFFFFF);
    repeat (30) @(negedge core_clk);
    chk(wr_valid, 1'b1);
    wr_ready = 1'b1;
    wait_words(16);
    // full page streams from the wrapped pointer (nibble 0), oldest kept byte first
    for (int k = 0; k < 16; k++)
      word(k, {5'h02, 4'(k)}, 8'h12 + 8'(k));
  endtask
  task automatic s_prot();
    logic [31:0] acks;
    fresh();
    unlock = 1'b1;
    for (int n = 0; n < 4; n++) begin
      cmd(codes[n], 1'b0, acks);
      chk(acks, 32'h7);
      chk(block_protect, (32'h2 << n) - 32'h1);
      cmd(codes[n], 1'b1, acks);
      chk(acks, 32'h0);
    end
    cmd(CODE_BLK1, 1'b0, acks);
    chk(acks, 32'h0);
    cmd(CODE_CLR, 1'b0, acks);
    chk(acks, 32'h7);
    chk(block_protect, 32'h0);
    cmd(CODE_BLK0, 1'b0, acks);
    memw(8'h7F, 8'h11, acks);
    chk(acks, 32'h3);
    memw(8'h80, 8'h22, acks);
    chk(acks, 32'h7);
    wait_words(1);
    word(0, 9'h080, 8'h22);
    cmd(CODE_BLK1, 1'b1, acks);
    chk(acks, 32'h1);
    cmd(CODE_CLR, 1'b0, acks);
    unlock = 1'b0;
  endtask
  task automatic s_half();
    logic [31:0] acks;
    fresh();
    pins = 3'h2; // commands ignore the select inputs
    cmd(CODE_HALF1, 1'b0, acks);
    chk(array_half, 1'b1);
    cmd(CODE_HALF0, 1'b1, acks);
    chk(acks, 32'h0);
    memw(8'h05, 8'hC3, acks);
    wait_words(1);
    word(0, 9'h105, 8'hC3);
    cmd(CODE_HALF0, 1'b0, acks);
    cmd(CODE_HALF0, 1'b1, acks);
    chk({array_half, acks[0]}, 2'b01);
  endtask
  task automatic s_busy();
    logic [31:0] acks;
    fresh();
    busy = 1'b1;
    memw(8'h01, 8'h02, acks);
    chk({write_busy, acks[0]}, 2'b10);
    cmd(CODE_BLK2, 1'b1, acks);
    chk(acks, 32'h0);
    busy = 1'b0;
    cmd(CODE_BLK2, 1'b1, acks);
    chk(acks, 32'h1);
    wait_words(0);
  endtask
  task automatic s_timeout();
    logic a1, a2, a3;
    fresh();
    to_cnt = 0;
    m.bus_start();
    m.send_byte({TYPE_MEM, pins, 1'b0}, a1);
    m.tick(LIM + 60);
    chk(to_cnt > 0, 1'b1);
    m.bus_stop();
    to_cnt = 0;
    m.bus_start();
    m.send_byte({TYPE_MEM, pins, 1'b0}, a1);
    m.send_byte(8'h44, a2);
    m.tick(LIM - 50);
    m.send_byte(8'h99, a3);
    m.bus_stop();
    chk({a1, a2, a3, 8'(to_cnt)}, 11'h700);
    wait_words(1);
    word(0, 9'h044, 8'h99);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    unlock = 1'b0;
    busy = 1'b0;
    wr_ready = 1'b1;
    pins = 3'h5;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    repeat (6) @(negedge core_clk);
    chk({array_half, block_protect}, 5'h00);
    s_byte();
    s_page();
    s_prot();
    s_half();
    s_busy();
    s_timeout();
    report_and_stop();
  end
  // watchdog: the full sequence needs well under 15000 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end
endmodule

// [inc/sew_pkg.sv]
package sew_pkg;

  // core clock and clock-low limit
  localparam int unsigned CLK_PERIOD_NS       = 100;
  localparam int unsigned NS_PER_MS           = 1000000;
  localparam int unsigned CLOCK_LOW_LIMIT_MS  = 30;
  // longest time: rounds down to whole cycles
  localparam int unsigned CLOCK_LOW_LIMIT_CYC = CLOCK_LOW_LIMIT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned LOW_CNT_W           = 20;

  // select code type field values
  localparam logic [3:0] TYPE_MEM = 4'hA;
  localparam logic [3:0] TYPE_CMD = 4'h6;

  // command codes in select bits 3..1
  localparam logic [2:0] CODE_BLK0  = 3'h1;
  localparam logic [2:0] CODE_BLK1  = 3'h4;
  localparam logic [2:0] CODE_BLK2  = 3'h5;
  localparam logic [2:0] CODE_BLK3  = 3'h0;
  localparam logic [2:0] CODE_CLR   = 3'h3;
  localparam logic [2:0] CODE_HALF0 = 3'h6;
  localparam logic [2:0] CODE_HALF1 = 3'h7;

  // array shape
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned LO_W       = 4;
  localparam int unsigned HI_W       = 4;
  localparam int unsigned NUM_BLOCKS = 4;
  localparam int unsigned ADDR_W     = 9;
  localparam logic [4:0]  PAGE_FULL  = 5'h10;

  // bit counting on the serial link
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // reset values
  localparam logic       HALF_RESET = 1'b0;
  localparam logic [3:0] PROT_RESET = 4'h0;

  // link frame states and pending operations
  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_ADDR, ST_DATA, ST_SKIP} sew_bus_e;
  typedef enum logic [2:0] {OP_NONE, OP_MEM, OP_SET, OP_CLR, OP_HALF} sew_op_e;

endpackage

// [logic/sew_page_buf.sv]
module sew_page_buf #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned WIDTH = 8,
  parameter int unsigned AW    = 4
) (
  // clock
  input  wire logic             core_clk,
  // write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side, data registered
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // storage array, no reset needed: only written slots are ever read
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge core_clk) begin
    rd_data_q <= mem_q[rd_addr];
  end

endmodule

// [logic/sew_write_protect.sv]
// Functional notes
// - clock held low to limit resets interface
// - shorter clock-low never resets the transfer
// - byte write acked, write starts at stop
// - protected word: data not acked, no write
// - during write cycle memory section silent
// - page write accepts up to sixteen bytes
// - stop writes received count from start address
// - only low address nibble increments per byte
// - over sixteen bytes wraps, last sixteen kept
// - blocks map by half and address bit seven
// - set command protects one block independently
// - clear command unprotects all four blocks
// - commands use byte-write frame, contents ignored
// - block status query acks when unprotected
// - half select commands set one-bit register
// - reset selects lower array half
// - half query acks when register is zero
// - set on protected block gets no ack
// - valid set or clear acked then performed
// - type field 1010 memory, 0110 commands
// - commands ignore select inputs
// - write cycle blocks both select types
module sew_write_protect
  import sew_pkg::*;
#(
  parameter int unsigned LOW_LIMIT_CYC = sew_pkg::CLOCK_LOW_LIMIT_CYC
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  // two-wire link pins
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  // select inputs and unlock level
  input  wire logic                      select_input_zero,
  input  wire logic                      select_input_one,
  input  wire logic                      select_input_two,
  input  wire logic                      elevated_unlock_voltage,
  // nonvolatile write stream
  output logic                           nvm_wr_valid,
  input  wire logic                      nvm_wr_ready,
  output logic [sew_pkg::ADDR_W-1:0]     nvm_wr_addr,
  output logic [7:0]                     nvm_wr_data,
  input  wire logic                      nvm_busy,
  // status
  output logic [sew_pkg::NUM_BLOCKS-1:0] block_protect,
  output logic                           array_half,
  output logic                           write_busy,
  output logic                           bus_timeout
);

  localparam logic [LOW_CNT_W-1:0] LOW_LIM = LOW_CNT_W'(LOW_LIMIT_CYC - 1);

  // synchronisers: stage 1 feeds stage 2 only
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic       scl_d1_q;
  logic       sda_d1_q;
  logic       scl_s;
  logic       sda_s;
  logic [2:0] sel_pins;
  logic       unlock_s;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_q  <= 6'h3F;
      sync2_q  <= 6'h3F;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      sync1_q  <= {elevated_unlock_voltage, select_input_two, select_input_one,
                   select_input_zero, sda_in, scl_in};
      sync2_q  <= sync1_q;
      scl_d1_q <= sync2_q[0];
      sda_d1_q <= sync2_q[1];
    end
  end

  assign scl_s    = sync2_q[0];
  assign sda_s    = sync2_q[1];
  assign sel_pins = sync2_q[4:2];
  assign unlock_s = sync2_q[5];

  // link events seen on the core clock
  logic rise_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;

  assign rise_ev  = scl_s & ~scl_d1_q;
  assign fall_ev  = ~scl_s & scl_d1_q;
  assign start_ev = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  assign stop_ev  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

  // clock-low timeout counter
  logic [LOW_CNT_W-1:0] low_cnt_q;
  logic                 tmo_ev;
  logic                 bus_timeout_q;

  always_ff @(posedge core_clk) begin
    if (srst || scl_s) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != LOW_LIM) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  // fires only at the full count
  assign tmo_ev = ~scl_s & (low_cnt_q == LOW_LIM) & (low_cnt_q != '0 || LOW_LIM == '0);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_timeout_q <= 1'b0;
    end else begin
      bus_timeout_q <= tmo_ev & ~(low_cnt_q == LOW_LIM & ~scl_d1_q & bus_timeout_q);
    end
  end

  // bus state, frame context and protection state
  sew_bus_e          state_q;
  sew_op_e           op_q;
  logic [3:0]        bit_cnt_q;
  logic              ack_phase_q;
  logic [7:0]        shift_q;
  logic              sda_oe_q;
  logic              armed_q;
  logic [1:0]        blk_sel_q;
  logic              half_arg_q;
  logic [HI_W-1:0]   addr_hi_q;
  logic [LO_W-1:0]   base_lo_q;
  logic [LO_W-1:0]   ptr_lo_q;
  logic [4:0]        count_q;
  logic [NUM_BLOCKS-1:0] prot_q;
  logic              half_q;
  logic              busy;
  logic              byte_done;
  logic              prot_hit;
  logic [1:0]        code_blk;
  logic              code_is_blk;

  assign byte_done = fall_ev & ~ack_phase_q & (bit_cnt_q == BITS_PER_BYTE);

  // block index from half and bit 7
  assign prot_hit = prot_q[{half_q, addr_hi_q[HI_W-1]}];

  // block number carried by a command code
  always_comb begin
    code_is_blk = 1'b1;
    unique case (shift_q[3:1])
      CODE_BLK0: code_blk = 2'h0;
      CODE_BLK1: code_blk = 2'h1;
      CODE_BLK2: code_blk = 2'h2;
      CODE_BLK3: code_blk = 2'h3;
      default: begin
        code_blk    = 2'h0;
        code_is_blk = 1'b0;
      end
    endcase
  end

  // link framing, ack decisions and address capture
  always_ff @(posedge core_clk) begin
    if (srst || tmo_ev) begin
      state_q     <= ST_IDLE;
      op_q        <= OP_NONE;
      bit_cnt_q   <= '0;
      ack_phase_q <= 1'b0;
      shift_q     <= '0;
      sda_oe_q    <= 1'b0;
      armed_q     <= 1'b0;
      blk_sel_q   <= '0;
      half_arg_q  <= 1'b0;
      addr_hi_q   <= '0;
      base_lo_q   <= '0;
      ptr_lo_q    <= '0;
      count_q     <= '0;
    end else if (start_ev) begin
      // a repeated start discards an unfinished write
      state_q     <= ST_SEL;
      op_q        <= OP_NONE;
      bit_cnt_q   <= '0;
      ack_phase_q <= 1'b0;
      sda_oe_q    <= 1'b0;
      armed_q     <= 1'b0;
    end else if (stop_ev) begin
      state_q     <= ST_IDLE;
      sda_oe_q    <= 1'b0;
      armed_q     <= 1'b0;
      ack_phase_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (rise_ev && !ack_phase_q && bit_cnt_q != BITS_PER_BYTE) begin
        shift_q   <= {shift_q[6:0], sda_s};
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
      if (fall_ev && ack_phase_q) begin
        // release after the ack clock
        ack_phase_q <= 1'b0;
        sda_oe_q    <= 1'b0;
        if (!sda_oe_q) begin
          state_q <= ST_SKIP;
        end
      end
      if (byte_done) begin
        bit_cnt_q   <= '0;
        ack_phase_q <= 1'b1;
        sda_oe_q    <= 1'b0;
        unique case (state_q)
          ST_SEL: begin
            if (shift_q[7:4] == TYPE_MEM && shift_q[3:1] == sel_pins) begin
              sda_oe_q <= ~busy;
              op_q     <= OP_MEM;
              state_q  <= shift_q[0] ? ST_SKIP : ST_ADDR;
            end else if (shift_q[7:4] == TYPE_CMD && !busy) begin
              blk_sel_q  <= code_blk;
              half_arg_q <= shift_q[1];
              state_q    <= shift_q[0] ? ST_SKIP : ST_ADDR;
              if (shift_q[0]) begin
                if (code_is_blk) begin
                  sda_oe_q <= ~prot_q[code_blk];
                end else if (shift_q[3:1] == CODE_HALF0) begin
                  sda_oe_q <= ~half_q;
                end
              end else if (code_is_blk) begin
                sda_oe_q <= unlock_s & ~prot_q[code_blk];
                op_q     <= OP_SET;
              end else if (shift_q[3:1] == CODE_CLR) begin
                sda_oe_q <= unlock_s;
                op_q     <= OP_CLR;
              end else if (shift_q[3:2] == CODE_HALF0[2:1]) begin
                sda_oe_q <= 1'b1;
                op_q     <= OP_HALF;
              end
            end else begin
              state_q <= ST_SKIP;
            end
          end
          ST_ADDR: begin
            sda_oe_q <= 1'b1;
            state_q  <= ST_DATA;
            if (op_q == OP_MEM) begin
              addr_hi_q <= shift_q[7:LO_W];
              base_lo_q <= shift_q[LO_W-1:0];
              ptr_lo_q  <= shift_q[LO_W-1:0];
              count_q   <= '0;
            end
          end
          ST_DATA: begin
            if (op_q == OP_MEM) begin
              sda_oe_q <= ~prot_hit;
              armed_q  <= ~prot_hit;
              if (!prot_hit) begin
                ptr_lo_q <= ptr_lo_q + 1'b1;
                if (count_q != PAGE_FULL) begin
                  count_q <= count_q + 1'b1;
                end
              end
            end else begin
              sda_oe_q <= 1'b1;
              armed_q  <= 1'b1;
              state_q  <= ST_SKIP;
            end
          end
          ST_SKIP: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // page buffer write on each accepted data byte
  logic       buf_we;
  logic [7:0] buf_rdata;
  logic [LO_W-1:0] rd_lo_q;

  // every accepted byte of a page lands here
  assign buf_we = byte_done & (state_q == ST_DATA) & (op_q == OP_MEM) & ~prot_hit;

  sew_page_buf #(
    .DEPTH (PAGE_BYTES),
    .WIDTH (8),
    .AW    (LO_W)
  ) u_page_buf (
    .core_clk  (core_clk),
    .wr_en     (buf_we),
    .wr_addr   (ptr_lo_q),
    .wr_data   (shift_q),
    .rd_addr   (rd_lo_q),
    .rd_data_q (buf_rdata)
  );

  logic commit;

  // act only at stop after a data byte
  assign commit = stop_ev & armed_q;

  // protection flags and array half register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      half_q <= HALF_RESET;
      prot_q <= PROT_RESET;
    end else if (commit) begin
      unique case (op_q)
        OP_SET: prot_q[blk_sel_q] <= 1'b1;
        OP_CLR: prot_q <= PROT_RESET;
        OP_HALF: half_q <= half_arg_q;
        default: prot_q <= prot_q;
      endcase
    end
  end

  // write stream: walks the page buffer into the output buffer
  logic            run_q;
  logic            pend_q;
  logic [4:0]      left_q;
  logic            wr_half_q;
  logic [HI_W-1:0] wr_hi_q;
  logic [LO_W-1:0] pend_lo_q;
  logic [1:0]      fcnt_q;
  logic            issue;
  logic            push;
  logic            pop;

  // registered read takes a cycle, so only one read is in flight
  assign issue = run_q & ~pend_q & (fcnt_q != 2'h2);
  assign push  = pend_q;
  assign pop   = nvm_wr_valid & nvm_wr_ready;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_q     <= 1'b0;
      pend_q    <= 1'b0;
      left_q    <= '0;
      rd_lo_q   <= '0;
      pend_lo_q <= '0;
      wr_half_q <= HALF_RESET;
      wr_hi_q   <= '0;
    end else if (commit && op_q == OP_MEM) begin
      // start and length from bytes received
      run_q     <= 1'b1;
      wr_half_q <= half_q;
      wr_hi_q   <= addr_hi_q;
      left_q    <= count_q;
      // past sixteen bytes the oldest kept sits at the pointer
      rd_lo_q   <= (count_q == PAGE_FULL) ? ptr_lo_q : base_lo_q;
    end else begin
      pend_q <= issue;
      if (issue) begin
        pend_lo_q <= rd_lo_q;
        rd_lo_q   <= rd_lo_q + 1'b1;
        left_q    <= left_q - 1'b1;
        run_q     <= (left_q != 5'h1);
      end
    end
  end

  // two-entry output buffer: head drives the ports
  logic [ADDR_W-1:0] e1_addr_q;
  logic [7:0]        e1_data_q;
  logic [ADDR_W-1:0] in_addr;

  assign in_addr = {wr_half_q, wr_hi_q, pend_lo_q};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fcnt_q       <= '0;
      nvm_wr_valid <= 1'b0;
      nvm_wr_addr  <= '0;
      nvm_wr_data  <= '0;
      e1_addr_q    <= '0;
      e1_data_q    <= '0;
    end else begin
      if (push && (fcnt_q == 2'h0 || (pop && fcnt_q == 2'h1))) begin
        nvm_wr_addr <= in_addr;
        nvm_wr_data <= buf_rdata;
      end else if (pop && fcnt_q == 2'h2) begin
        nvm_wr_addr <= e1_addr_q;
        nvm_wr_data <= e1_data_q;
      end
      if (push && (fcnt_q == 2'h2 || (fcnt_q == 2'h1 && !pop))) begin
        e1_addr_q <= in_addr;
        e1_data_q <= buf_rdata;
      end
      fcnt_q       <= fcnt_q + 2'(push) - 2'(pop);
      nvm_wr_valid <= (fcnt_q + 2'(push) - 2'(pop)) != 2'h0;
    end
  end

  // busy covers stream, buffer and the array's own cycle
  assign busy = run_q | pend_q | (fcnt_q != 2'h0) | nvm_busy;

  // status outputs from flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
      block_protect <= PROT_RESET;
      array_half    <= HALF_RESET;
      write_busy    <= 1'b0;
      bus_timeout   <= 1'b0;
    end else begin
      sda_out       <= 1'b0;
      sda_oe        <= sda_oe_q;
      block_protect <= prot_q;
      array_half    <= half_q;
      write_busy    <= busy;
      bus_timeout   <= bus_timeout_q;
    end
  end

endmodule
